// ==== src/mark_sel_pkg.sv ====
// Constants for the mark and sync input selection block
package mark_sel_pkg;
  localparam int  SYNC_STAGES    = 2;
  localparam bit  ENABLE_ON      = 1'h1;
  localparam bit  SYNC_SRC_DIFF  = 1'h1;
  localparam bit  SYNC_SRC_PIN   = 1'h0;
  localparam bit  SYNC_ASSERTED  = 1'h0;
  localparam bit  SYNC_RELEASED  = 1'h1;
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_CGS  = 2'h1;
  localparam logic [1:0] PH_ILAS = 2'h2;
endpackage

// ==== src/sync_timestamp_input_select.sv ====
// Selection of the differential mark input as timestamp and/or sync request
// Behaviour
// - Timestamp enable tags sample from mark input
// - Source select one takes sync from mark
// - Mark may serve timestamp and sync together
// - Sync request is active low
// - Mark ignored unless receiver enable set
// - Receiver may stay disabled using pin sync
// - Source select zero takes sync from pin
// - Low starts code sync, high starts alignment
`timescale 1ns/1ps
module sync_timestamp_input_select (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic diff_mark_input,
  input  wire logic single_ended_sync_pin,
  input  wire logic timestamp_enable,
  input  wire logic sync_source_select,
  input  wire logic diff_receiver_enable,
  output logic      sample_mark,
  output logic      sync_request,
  output logic      code_sync_start,
  output logic      lane_align_start
);
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_CGS  = 2'h1,
    LINK_ILAS = 2'h2
  } link_state_t;

  logic       mark_meta_r;
  logic       mark_sync_r;
  logic       mark_hist_r;
  logic       pin_meta_r;
  logic       pin_sync_r;
  logic [mark_sel_pkg::SYNC_STAGES:0] recv_on_r;
  logic       sync_n_sel;
  link_state_t link_r;

  // Disabled receiver reads as released, so a floating mark input stays harmless
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mark_meta_r <= mark_sel_pkg::SYNC_RELEASED;
      mark_sync_r <= mark_sel_pkg::SYNC_RELEASED;
      mark_hist_r <= mark_sel_pkg::SYNC_RELEASED;
    end else if (diff_receiver_enable == mark_sel_pkg::ENABLE_ON) begin
      mark_meta_r <= diff_mark_input;
      mark_sync_r <= mark_meta_r;
      mark_hist_r <= mark_sync_r;
    end else begin
      mark_meta_r <= mark_sel_pkg::SYNC_RELEASED;
      mark_sync_r <= mark_sel_pkg::SYNC_RELEASED;
      mark_hist_r <= mark_sel_pkg::SYNC_RELEASED;
    end
  end

  // Timestamp waits until enabling has flushed the stages, else stale ones mark
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      recv_on_r <= 3'h0;
    end else begin
      recv_on_r <= {recv_on_r[mark_sel_pkg::SYNC_STAGES-1:0], diff_receiver_enable};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_meta_r <= mark_sel_pkg::SYNC_RELEASED;
      pin_sync_r <= mark_sel_pkg::SYNC_RELEASED;
    end else begin
      pin_meta_r <= single_ended_sync_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Source mux; mark path still feeds timestamp when it is the sync source
  always_comb begin
    if (sync_source_select == mark_sel_pkg::SYNC_SRC_DIFF) begin
      sync_n_sel = mark_sync_r;
    end else begin
      sync_n_sel = pin_sync_r;
    end
  end

  // Mark level over two synced samples; first stage stays private to the synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sample_mark <= 1'h0;
    end else begin
      sample_mark <= (timestamp_enable == mark_sel_pkg::ENABLE_ON) &&
                     (diff_receiver_enable == mark_sel_pkg::ENABLE_ON) &&
                     (&recv_on_r) && mark_sync_r && mark_hist_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_request <= 1'h0;
    end else begin
      sync_request <= (sync_n_sel == mark_sel_pkg::SYNC_ASSERTED);
    end
  end

  // Link phase: low enters code sync, rising edge starts alignment
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_r           <= LINK_IDLE;
      code_sync_start  <= 1'h0;
      lane_align_start <= 1'h0;
    end else begin
      code_sync_start  <= 1'h0;
      lane_align_start <= 1'h0;
      case (link_r)
        LINK_IDLE, LINK_ILAS: begin
          if (sync_n_sel == mark_sel_pkg::SYNC_ASSERTED) begin
            link_r          <= LINK_CGS;
            code_sync_start <= 1'h1;
          end
        end
        LINK_CGS: begin
          if (sync_n_sel == mark_sel_pkg::SYNC_RELEASED) begin
            link_r           <= LINK_ILAS;
            lane_align_start <= 1'h1;
          end
        end
        default: begin
          link_r <= LINK_IDLE;
        end
      endcase
    end
  end

  sequence seq_sync_low;
    sync_n_sel == mark_sel_pkg::SYNC_ASSERTED;
  endsequence

  sequence seq_sync_high;
    sync_n_sel == mark_sel_pkg::SYNC_RELEASED;
  endsequence

  sequence seq_in_cgs;
    link_r == LINK_CGS;
  endsequence

  AST_SYNC_ACTIVE_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_sync_low |=> sync_request)
    else $error("sync request not raised on low input");

  AST_SYNC_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_sync_high |=> !sync_request)
    else $error("sync request held on high input");

  AST_PIN_SOURCE: assert property (@(posedge mclk) disable iff (!rst_n)
    !sync_source_select |-> sync_n_sel == pin_sync_r)
    else $error("pin source not selected");

  AST_PIN_REQUEST: assert property (@(posedge mclk) disable iff (!rst_n)
    !sync_source_select && !pin_sync_r |=> sync_request)
    else $error("pin sync request lost");

  AST_DIFF_SOURCE: assert property (@(posedge mclk) disable iff (!rst_n)
    sync_source_select |-> sync_n_sel == mark_sync_r)
    else $error("mark source not selected");

  AST_MARK_REQUEST: assert property (@(posedge mclk) disable iff (!rst_n)
    sync_source_select && !mark_sync_r |=> sync_request)
    else $error("mark sync request lost");

  AST_RECV_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !diff_receiver_enable [*3] |-> mark_sync_r && !sample_mark)
    else $error("mark input not ignored while receiver off");

  AST_RECV_SETTLE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(diff_receiver_enable) |=> !sample_mark [*3])
    else $error("stale mark right after enabling receiver");

  AST_PIN_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
    !diff_receiver_enable && !sync_source_select && !pin_sync_r |=> sync_request)
    else $error("pin sync lost with receiver off");

  AST_TS_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !timestamp_enable |=> !sample_mark)
    else $error("timestamp when disabled");

  AST_TS_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    !mark_sync_r |=> !sample_mark)
    else $error("timestamp while mark low");

  AST_PIN_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |-> ##2 pin_sync_r == $past(single_ended_sync_pin, 2))
    else $error("pin synchroniser depth wrong");

  AST_MARK_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && diff_receiver_enable) [*3] |-> mark_sync_r == $past(diff_mark_input, 2))
    else $error("mark synchroniser depth wrong");

  AST_CGS_THEN_ILAS: assert property (@(posedge mclk) disable iff (!rst_n)
    lane_align_start |-> $past(link_r) == LINK_CGS && link_r == LINK_ILAS)
    else $error("alignment without code sync");

  AST_CGS_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
    (link_r != LINK_CGS) and seq_sync_low |=> code_sync_start)
    else $error("code sync start missed");

  AST_ILAS_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_in_cgs and seq_sync_high |=> lane_align_start)
    else $error("alignment start missed");

  AST_CS_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    code_sync_start |=> !code_sync_start)
    else $error("code sync start longer than one cycle");

  AST_LA_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    lane_align_start |=> !lane_align_start)
    else $error("alignment start longer than one cycle");

  AST_CS_WITH_REQUEST: assert property (@(posedge mclk) disable iff (!rst_n)
    code_sync_start |-> sync_request)
    else $error("code sync start without request");

  AST_LA_WITH_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    lane_align_start |-> !sync_request)
    else $error("alignment start while request held");

  AST_BOTH_ROLES: assert property (@(posedge mclk) disable iff (!rst_n)
    sync_source_select && timestamp_enable && diff_receiver_enable && (&recv_on_r)
      && mark_sync_r && mark_hist_r |=> sample_mark)
    else $error("timestamp lost while mark carries sync");
endmodule // sync_timestamp_input_select

// ==== verification/link_rx_model.sv ====
// Link receiver model driving the sync line
`timescale 1ns/1ps
module link_rx_model (
  input  wire logic mclk,
  input  wire logic want_sync,
  output logic      sync_n
);
  // Low asks for code sync, high releases for alignment
  always_ff @(posedge mclk) sync_n <= ~want_sync;
endmodule // link_rx_model

// ==== verification/tb_top.sv ====
// Random and corner bench for the mark and sync selection
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_n, ts, sel, en, want, other, sync_n, sm, sr, cs, la, pe;
  logic [4:0] pv, cfg;
  logic [4:0] cn [9] = '{5'h02, 5'h00, 5'h0E, 5'h0C, 5'h1E, 5'h1C, 5'h0A, 5'h15, 5'h11};
  int fail_count, n_compared, cyc, ncs, nla;
  wire mk = sel ? sync_n : other;
  wire pn = sel ? other : sync_n;
  link_rx_model link_rx_model_inst (.mclk(mclk), .want_sync(want), .sync_n(sync_n));
  sync_timestamp_input_select sync_timestamp_input_select_inst (.mclk(mclk), .rst_n(rst_n),
    .diff_mark_input(mk), .single_ended_sync_pin(pn), .timestamp_enable(ts),
    .sync_source_select(sel), .diff_receiver_enable(en), .sample_mark(sm),
    .sync_request(sr), .code_sync_start(cs), .lane_align_start(la));
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    ncs += int'(cs === 1'b1);
    nla += int'(la === 1'b1);
    if (cyc == 5000) begin fail_count++; summarize(); end
  end
  function automatic logic [1:0] exp_f(logic t, s, e, m, p);
    logic line;
    line = s ? (e ? m : 1'b1) : p;
    return {~line, e & t & m};
  endfunction
  task automatic chk(string nm, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step(logic [4:0] v);
    logic [1:0] e;
    int c0, l0;
    @(posedge mclk);
    {ts, sel, en, want, other} <= v;
    #1 c0 = ncs;
    l0 = nla;
    repeat (6) @(posedge mclk);
    #1 e = exp_f(v[4], v[3], v[2], v[3] ? ~v[1] : v[0], v[3] ? v[0] : ~v[1]);
    chk("sync_request", e[1], sr);
    chk("sample_mark", e[0], sm);
    if (v[4:2] == pv[4:2]) begin
      chk("code_sync_start", e[1] & ~pe, ncs != c0);
      chk("lane_align_start", ~e[1] & pe, nla != l0);
    end
    pv = v;
    pe = e[1];
  endtask
  initial begin
    {ts, sel, en, want, other} = 5'h00;
    {pv, pe, cfg} = 0;
    rst_n = 0;
    void'($urandom(40));
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    foreach (cn[i]) step(cn[i]);
    // Mid-run reset while the pin asks for sync: outputs clear, code sync restarts
    step(5'h12);
    @(posedge mclk);
    rst_n <= 0;
    repeat (3) @(posedge mclk);
    #1 chk("sync_request in reset", 1'h0, sr);
    chk("sample_mark in reset", 1'h0, sm);
    chk("code_sync_start in reset", 1'h0, cs);
    chk("lane_align_start in reset", 1'h0, la);
    @(posedge mclk);
    rst_n <= 1;
    pe = 0;
    step(5'h12);
    repeat (300) begin
      if ($urandom % 4 == 0) cfg = 5'($urandom);
      step({cfg[4:2], 2'($urandom)});
    end
    summarize();
  end
endmodule // tb_top
